// >>> hw/ssa_map.vh
// Save area layout constants
`ifndef SSA_MAP_VH
`define SSA_MAP_VH
`define SSA_OFF_FCW        10'd0
`define SSA_OFF_FSW        10'd2
`define SSA_OFF_TAGS       10'd4
`define SSA_OFF_FOP        10'd6
`define SSA_OFF_FIP        10'd8
`define SSA_OFF_FCS        10'd12
`define SSA_OFF_FDP        10'd16
`define SSA_OFF_FDS        10'd20
`define SSA_OFF_SIMD_CONTROL_STATUS      10'd24
`define SSA_OFF_MXMASK     10'd28
`define SSA_OFF_STK        10'd32
`define SSA_OFF_SIMD       10'd160
`define SSA_OFF_SIMD_HI    10'd288
`define SSA_OFF_EXT        10'd576
`define SSA_TAG_EMPTY      2'h3
`define SSA_TAG_VALID      2'h0
`define SSA_TAG_ZERO       2'h1
`define SSA_TAG_SPECIAL    2'h2
`define SSA_SEL_ZERO       16'h0000
`define SSA_EFE_FP         0
`define SSA_EFE_SIMD       1
`define SSA_EFE_VEC        2
`define SSA_EFE_BREG       3
`define SSA_EFE_BCFG       4
`define SSA_CMP_FMT_BIT    63
`define SSA_QRY_SELDEP_BIT 13
`define SSA_LINE_BYTES     16
`endif

// >>> hw/ssa_ram.v
// Holds the save area as 128-bit lines with registered read data
`default_nettype none
module ssa_ram #(
  parameter AW = 7
) (
  input  wire           clock,
  input  wire           we,
  input  wire [AW-1:0]  waddr,
  input  wire [127:0]   wdata,
  input  wire [15:0]    wbe,
  input  wire [AW-1:0]  raddr,
  output reg  [127:0]   rdata
);
  reg [127:0] mem [0:(1<<AW)-1];
  integer i;
  always @(posedge clock) begin
    if (we) begin
      for (i = 0; i < 16; i = i + 1) begin
        if (wbe[i]) begin
          mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
        end
      end
    end
    rdata <= mem[raddr];
  end
endmodule // ssa_ram
`default_nettype wire

// >>> hw/ssa_engine.v
// Save and restore engine for the processor state save area
`include "ssa_map.vh"
`default_nettype none
// How it works
// - Each component starts at its section's byte 0
// - Control, status, opcode at bytes 1:0,3:2,7:6
// - Save: tag bit j is 0 if empty
// - Restore: bit 0 gives empty tag, else derived
// - Narrow form: instruction pointer low in 11:8
// - Narrow form: data pointer low in 19:16
// - Query bit 13 zeroes selectors, restore ignores
// - Wide form: full 64-bit pointers
// - Stack regs in 128-bit slots, low 80 bits
// - Stack component needs save enable only
// - Feature enable bit 0 always one
// - Control/status at 27:24, reserved bits fault
// - Mask at 31:28, ignored on restore
// - SIMD regs 0-7 and 8-15 placement
// - Outside 64-bit mode upper SIMD untouched
// - SIMD component needs enable bits 1
// - Upper halves are component 2 at query offset
// - Halves 8-15 only in 64-bit mode
// - Component 2 and vector ops need bit 2
// - Bounds regs component 3, config component 4
// - Standard offsets for components 3 and 4
// - Bounds components need bits 4:3 both set
// - Bitmap bit 63 selects compacted layout
// - Extended region begins at byte 576
module ssa_engine #(
  parameter [9:0]  VEC_OFF     = 10'd576,
  parameter [9:0]  VEC_SIZE    = 10'd256,
  parameter [9:0]  BREG_OFF    = 10'd832,
  parameter [9:0]  BREG_SIZE   = 10'd64,
  parameter [9:0]  BCFG_OFF    = 10'd896,
  parameter [9:0]  BCFG_SIZE   = 10'd64,
  parameter [31:0] SIMD_CONTROL_STATUS_MASK  = 32'h0000ffff,
  parameter        AW          = 7
) (
  input  wire          clock,
  input  wire          rst_n,
  input  wire          save_req,
  input  wire          restore_req,
  input  wire [4:0]    req_mask,
  input  wire          wide_operand_prefix_bit,
  input  wire          mode64,
  input  wire          os_save_enable,
  input  wire          efe_wr,
  input  wire [4:0]    efe_wdata,
  input  wire          query_sel_dep,
  input  wire [63:0]   compaction_bitmap,
  input  wire [15:0]   fp_control_word,
  input  wire [15:0]   fp_status_word,
  input  wire [10:0]   fp_last_opcode,
  input  wire [15:0]   fp_tag_word,
  input  wire [63:0]   fp_instr_pointer,
  input  wire [63:0]   fp_data_pointer,
  input  wire [15:0]   fp_code_selector,
  input  wire [15:0]   fp_data_selector,
  input  wire [639:0]  fp_stack_regs,
  input  wire [31:0]   simd_control_status,
  input  wire [2047:0] simd128_regs,
  input  wire [2047:0] vector256_upper_halves,
  input  wire [511:0]  bounds_regs_component,
  input  wire [63:0]   bounds_user_config,
  input  wire [63:0]   bounds_status_reg,
  output reg  [4:0]    extended_feature_enable,
  output wire          busy,
  output reg           done,
  output reg           fault,
  output reg           fmt_compacted,
  output reg           vec_allowed,
  output reg           bounds_allowed,
  output reg  [9:0]    query_offset_vec,
  output reg  [9:0]    query_offset_breg,
  output reg  [9:0]    query_offset_bcfg,
  output reg  [9:0]    query_size_vec,
  output reg           ld_fp,
  output reg  [15:0]   ld_fp_control_word,
  output reg  [15:0]   ld_fp_status_word,
  output reg  [10:0]   ld_fp_last_opcode,
  output reg  [15:0]   ld_fp_tag_word,
  output reg  [63:0]   ld_fp_instr_pointer,
  output reg  [63:0]   ld_fp_data_pointer,
  output reg  [15:0]   ld_fp_code_selector,
  output reg  [15:0]   ld_fp_data_selector,
  output reg           ld_stack,
  output reg  [2:0]    ld_stack_idx,
  output reg  [79:0]   ld_stack_value,
  output reg           ld_simd_csr,
  output reg  [31:0]   ld_simd_control_status,
  output reg           ld_simd,
  output reg  [3:0]    ld_simd_idx,
  output reg  [127:0]  ld_simd_value,
  output reg           ld_vec,
  output reg  [3:0]    ld_vec_idx,
  output reg  [127:0]  ld_vec_value,
  output reg           ld_breg,
  output reg  [1:0]    ld_breg_idx,
  output reg  [127:0]  ld_breg_value,
  output reg           ld_bcfg,
  output reg  [63:0]   ld_bounds_user_config,
  output reg  [63:0]   ld_bounds_status_reg
);
  localparam ST_IDLE = 2'd0;
  localparam ST_RUN  = 2'd1;
  localparam ST_WAIT = 2'd2;
  localparam ST_LAST = 2'd3;

  localparam [5:0] N_STEPS = 6'd47;

  reg  [1:0]   state;
  reg  [5:0]   step;
  reg  [5:0]   rd_step;
  reg          is_save;
  reg          wide;
  reg          m64;
  reg          seldep;
  reg  [4:0]   act;
  reg          compact;
  reg  [15:0]  fp_tag_keep;

  reg          we;
  reg  [AW-1:0] waddr;
  reg  [127:0] wdata;
  reg  [15:0]  wbe;
  wire [127:0] rdata;
  reg  [AW-1:0] raddr;

  function [9:0] sect_off;
    input [2:0]  comp;
    input        cmp;
    input [63:0] bm;
    reg   [9:0]  loc;
    begin
      loc = `SSA_OFF_EXT;
      if (!cmp) begin
        sect_off = (comp == 3'd2) ? VEC_OFF : (comp == 3'd3) ? BREG_OFF : BCFG_OFF;
      end else begin
        if (comp > 3'd2 && bm[2]) begin
          loc = loc + VEC_SIZE;
        end
        if (comp > 3'd3 && bm[3]) begin
          loc = loc + BREG_SIZE;
        end
        sect_off = loc;
      end
    end
  endfunction

  function [2:0] step_comp;
    input [5:0] s;
    begin
      if (s < 6'd10) begin
        step_comp = 3'd0;
      end else if (s < 6'd26) begin
        step_comp = 3'd1;
      end else if (s < 6'd42) begin
        step_comp = 3'd2;
      end else if (s < 6'd46) begin
        step_comp = 3'd3;
      end else begin
        step_comp = 3'd4;
      end
    end
  endfunction

  function [9:0] step_byte;
    input [5:0] s;
    input       cmp;
    input [63:0] bm;
    begin
      if (s < 6'd2) begin
        step_byte = {5'h0, s[0], 4'h0};
      end else if (s < 6'd10) begin
        step_byte = `SSA_OFF_STK + {s - 6'd2, 4'h0};
      end else if (s < 6'd26) begin
        step_byte = `SSA_OFF_SIMD + {s - 6'd10, 4'h0};
      end else if (s < 6'd42) begin
        step_byte = sect_off(3'd2, cmp, bm) + {s - 6'd26, 4'h0};
      end else if (s < 6'd46) begin
        step_byte = sect_off(3'd3, cmp, bm) + {s - 6'd42, 4'h0};
      end else begin
        step_byte = sect_off(3'd4, cmp, bm);
      end
    end
  endfunction

  function step_live;
    input [5:0] s;
    input [4:0] a;
    input       m;
    input       cmp;
    input [63:0] bm;
    reg   [2:0] c;
    begin
      c = step_comp(s);
      step_live = a[c];
      if (s == 6'd1) begin
        step_live = a[0] | a[1];
      end
      if (s >= 6'd18 && s < 6'd26 && !m) begin
        step_live = 1'b0;
      end
      if (s >= 6'd34 && s < 6'd42 && !m) begin
        step_live = 1'b0;
      end
      if (cmp && c >= 3'd2 && !bm[c]) begin
        step_live = 1'b0;
      end
    end
  endfunction

  function tag_empty;
    input [15:0] tw;
    input [2:0]  j;
    begin
      tag_empty = (tw[j*2 +: 2] == `SSA_TAG_EMPTY);
    end
  endfunction

  function [1:0] tag_of;
    input [79:0] v;
    begin
      if (v[78:64] == 15'h7fff) begin
        tag_of = `SSA_TAG_SPECIAL;
      end else if (v[78:0] == 79'h0) begin
        tag_of = `SSA_TAG_ZERO;
      end else if (v[78:64] == 15'h0 || !v[63]) begin
        tag_of = `SSA_TAG_SPECIAL;
      end else begin
        tag_of = `SSA_TAG_VALID;
      end
    end
  endfunction

  ssa_ram #(
    .AW(AW)
  ) u_ram (
    .clock(clock),
    .we   (we),
    .waddr(waddr),
    .wdata(wdata),
    .wbe  (wbe),
    .raddr(raddr),
    .rdata(rdata)
  );

  assign busy = (state != ST_IDLE);

  wire bnd_en = extended_feature_enable[`SSA_EFE_BCFG] & extended_feature_enable[`SSA_EFE_BREG];
  wire [4:0] efe_gate = {bnd_en, bnd_en, extended_feature_enable[`SSA_EFE_VEC],
                         extended_feature_enable[`SSA_EFE_SIMD], 1'b1};

  reg [127:0] sv_data;
  reg [15:0]  sv_be;
  reg [7:0]   abr;
  integer     j;
  integer     t;
  always @* begin
    sv_data = 128'h0;
    sv_be   = 16'hffff;
    abr     = 8'h0;
    for (j = 0; j < 8; j = j + 1) begin
      abr[j] = !tag_empty(fp_tag_word, j[2:0]);
    end
    if (step == 6'd0) begin
      sv_data[15:0]   = fp_control_word;
      sv_data[31:16]  = fp_status_word;
      sv_data[39:32]  = abr;
      sv_data[58:48]  = fp_last_opcode;
      if (wide) begin
        sv_data[127:64] = fp_instr_pointer;
      end else begin
        sv_data[95:64]  = fp_instr_pointer[31:0];
        sv_data[111:96] = seldep ? `SSA_SEL_ZERO : fp_code_selector;
      end
    end else if (step == 6'd1) begin
      if (wide) begin
        sv_data[63:0] = fp_data_pointer;
      end else begin
        sv_data[31:0]  = fp_data_pointer[31:0];
        sv_data[47:32] = seldep ? `SSA_SEL_ZERO : fp_data_selector;
      end
      sv_data[95:64]  = simd_control_status;
      sv_data[127:96] = SIMD_CONTROL_STATUS_MASK;
      sv_be = {act[1] ? 8'hff : 8'h00, act[0] ? 8'hff : 8'h00};
    end else if (step < 6'd10) begin
      sv_data[79:0] = fp_stack_regs[(step - 6'd2)*80 +: 80];
    end else if (step < 6'd26) begin
      sv_data = simd128_regs[(step - 6'd10)*128 +: 128];
    end else if (step < 6'd42) begin
      sv_data = vector256_upper_halves[(step - 6'd26)*128 +: 128];
    end else if (step < 6'd46) begin
      sv_data = bounds_regs_component[(step - 6'd42)*128 +: 128];
    end else begin
      sv_data = {bounds_status_reg, bounds_user_config};
    end
  end

  wire [9:0] cur_byte = step_byte(step, compact, compaction_bitmap);
  wire       cur_live = step_live(step, act, m64, compact, compaction_bitmap);
  wire       rd_live  = step_live(rd_step, act, m64, compact, compaction_bitmap);

  always @* begin
    we    = is_save && (state == ST_RUN) && cur_live;
    waddr = {{(AW-6){1'b0}}, cur_byte[9:4]};
    wdata = sv_data;
    wbe   = sv_be;
    raddr = {{(AW-6){1'b0}}, cur_byte[9:4]};
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      extended_feature_enable <= 5'h01;
      state <= ST_IDLE;
      step <= 6'h0;
      rd_step <= 6'h0;
      is_save <= 1'b0;
      wide <= 1'b0;
      m64 <= 1'b0;
      seldep <= 1'b0;
      act <= 5'h0;
      compact <= 1'b0;
      fp_tag_keep <= 16'hffff;
      done <= 1'b0;
      fault <= 1'b0;
      fmt_compacted <= 1'b0;
      vec_allowed <= 1'b0;
      bounds_allowed <= 1'b0;
      query_offset_vec <= 10'h0;
      query_offset_breg <= 10'h0;
      query_offset_bcfg <= 10'h0;
      query_size_vec <= 10'h0;
      ld_fp <= 1'b0;
      ld_fp_control_word <= 16'h0;
      ld_fp_status_word <= 16'h0;
      ld_fp_last_opcode <= 11'h0;
      ld_fp_tag_word <= 16'hffff;
      ld_fp_instr_pointer <= 64'h0;
      ld_fp_data_pointer <= 64'h0;
      ld_fp_code_selector <= 16'h0;
      ld_fp_data_selector <= 16'h0;
      ld_stack <= 1'b0;
      ld_stack_idx <= 3'h0;
      ld_stack_value <= 80'h0;
      ld_simd_csr <= 1'b0;
      ld_simd_control_status <= 32'h0;
      ld_simd <= 1'b0;
      ld_simd_idx <= 4'h0;
      ld_simd_value <= 128'h0;
      ld_vec <= 1'b0;
      ld_vec_idx <= 4'h0;
      ld_vec_value <= 128'h0;
      ld_breg <= 1'b0;
      ld_breg_idx <= 2'h0;
      ld_breg_value <= 128'h0;
      ld_bcfg <= 1'b0;
      ld_bounds_user_config <= 64'h0;
      ld_bounds_status_reg <= 64'h0;
    end else begin
      done <= 1'b0;
      ld_fp <= 1'b0;
      ld_stack <= 1'b0;
      ld_simd_csr <= 1'b0;
      ld_simd <= 1'b0;
      ld_vec <= 1'b0;
      ld_breg <= 1'b0;
      ld_bcfg <= 1'b0;
      if (efe_wr) begin
        extended_feature_enable <= efe_wdata | 5'h01;
      end
      vec_allowed <= os_save_enable & extended_feature_enable[`SSA_EFE_VEC];
      bounds_allowed <= os_save_enable & bnd_en;
      query_offset_vec  <= VEC_OFF;
      query_offset_breg <= BREG_OFF;
      query_offset_bcfg <= BCFG_OFF;
      query_size_vec    <= VEC_SIZE;
      case (state)
        ST_IDLE: begin
          if ((save_req || restore_req) && os_save_enable) begin
            is_save <= save_req;
            wide <= wide_operand_prefix_bit;
            m64 <= mode64;
            seldep <= query_sel_dep;
            act <= req_mask & efe_gate & extended_feature_enable;
            compact <= compaction_bitmap[`SSA_CMP_FMT_BIT];
            fmt_compacted <= compaction_bitmap[`SSA_CMP_FMT_BIT];
            fault <= 1'b0;
            step <= 6'h0;
            fp_tag_keep <= fp_tag_word;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          rd_step <= step;
          if (!is_save) begin
            state <= ST_WAIT;
          end else if (step == N_STEPS - 6'd1) begin
            state <= ST_LAST;
          end else begin
            step <= step + 6'd1;
          end
        end
        ST_WAIT: begin
          if (rd_live) begin
            if (rd_step == 6'd0) begin
              ld_fp <= act[0];
              ld_fp_control_word <= rdata[15:0];
              ld_fp_status_word <= rdata[31:16];
              ld_fp_last_opcode <= rdata[58:48];
              ld_fp_instr_pointer <= wide ? rdata[127:64] : {32'h0, rdata[95:64]};
              if (!seldep && !wide) begin
                ld_fp_code_selector <= rdata[111:96];
              end
              for (t = 0; t < 8; t = t + 1) begin
                if (!rdata[32 + t]) begin
                  fp_tag_keep[t*2 +: 2] <= `SSA_TAG_EMPTY;
                end else begin
                  fp_tag_keep[t*2 +: 2] <= `SSA_TAG_VALID;
                end
              end
            end else if (rd_step == 6'd1) begin
              if (act[0]) begin
                ld_fp_data_pointer <= wide ? rdata[63:0] : {32'h0, rdata[31:0]};
                if (!seldep && !wide) begin
                  ld_fp_data_selector <= rdata[47:32];
                end
              end
              if (act[1]) begin
                if ((rdata[95:64] & ~SIMD_CONTROL_STATUS_MASK) != 32'h0) begin
                  fault <= 1'b1;
                end else begin
                  ld_simd_csr <= 1'b1;
                  ld_simd_control_status <= rdata[95:64];
                end
              end
            end else if (rd_step < 6'd10) begin
              ld_stack <= 1'b1;
              ld_stack_idx <= rd_step[2:0] - 3'd2;
              ld_stack_value <= rdata[79:0];
              if (fp_tag_keep[(rd_step - 6'd2)*2 +: 2] != `SSA_TAG_EMPTY) begin
                fp_tag_keep[(rd_step - 6'd2)*2 +: 2] <= tag_of(rdata[79:0]);
              end
            end else if (rd_step < 6'd26) begin
              ld_simd <= 1'b1;
              ld_simd_idx <= rd_step[3:0] - 4'd10;
              ld_simd_value <= rdata;
            end else if (rd_step < 6'd42) begin
              ld_vec <= 1'b1;
              ld_vec_idx <= rd_step[3:0] - 4'd10;
              ld_vec_value <= rdata;
            end else if (rd_step < 6'd46) begin
              ld_breg <= 1'b1;
              ld_breg_idx <= rd_step[1:0] - 2'd2;
              ld_breg_value <= rdata;
            end else begin
              ld_bcfg <= 1'b1;
              ld_bounds_user_config <= rdata[63:0];
              ld_bounds_status_reg <= rdata[127:64];
            end
          end
          if (rd_step == N_STEPS - 6'd1) begin
            state <= ST_LAST;
          end else begin
            step <= rd_step + 6'd1;
            state <= ST_RUN;
          end
        end
        ST_LAST: begin
          if (!is_save && act[0]) begin
            ld_fp_tag_word <= fp_tag_keep;
          end
          done <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // ssa_engine
`default_nettype wire

// >>> tb/ssa_engine_props.sv
// Property checker for the save area engine
`default_nettype none
module ssa_engine_props #(
  parameter [9:0] VEC_OFF  = 10'd576,
  parameter [9:0] VEC_SIZE = 10'd256,
  parameter [9:0] BREG_OFF = 10'd832,
  parameter [9:0] BCFG_OFF = 10'd896
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        save_req,
  input wire logic        restore_req,
  input wire logic        mode64,
  input wire logic        os_save_enable,
  input wire logic        efe_wr,
  input wire logic [4:0]  efe_wdata,
  input wire logic [63:0] compaction_bitmap,
  input wire logic [4:0]  extended_feature_enable,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        fmt_compacted,
  input wire logic        vec_allowed,
  input wire logic        bounds_allowed,
  input wire logic [9:0]  query_offset_vec,
  input wire logic [9:0]  query_offset_breg,
  input wire logic [9:0]  query_offset_bcfg,
  input wire logic [9:0]  query_size_vec,
  input wire logic        ld_simd,
  input wire logic [3:0]  ld_simd_idx,
  input wire logic        ld_vec,
  input wire logic [3:0]  ld_vec_idx
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic m64_run;
  logic cmp_run;
  wire  start = !busy && (save_req || restore_req) && os_save_enable;
  // Mode and format captured when an operation is taken
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      m64_run <= 1'b0;
      cmp_run <= 1'b0;
    end else if (start) begin
      m64_run <= mode64;
      cmp_run <= compaction_bitmap[63];
    end
  end
  sequence save_start_s;
    start && save_req;
  endsequence
  sequence rest_start_s;
    start && !save_req;
  endsequence
  save_len_a: assert property (save_start_s |-> ##[1:60] done)
    else $error("save did not finish");
  rest_len_a: assert property (rest_start_s |-> ##[1:120] done)
    else $error("restore did not finish");
  refuse_off_a: assert property (!busy && !os_save_enable |=> !busy)
    else $error("operation taken while disabled");
  efe_bit0_a: assert property (extended_feature_enable[0])
    else $error("enable bit 0 cleared");
  efe_write_a: assert property (efe_wr |=> extended_feature_enable == ($past(efe_wdata) | 5'h01))
    else $error("enable write wrong");
  simd_hi_a: assert property (ld_simd && ld_simd_idx[3] |-> m64_run)
    else $error("upper simd loaded outside wide mode");
  vec_hi_a: assert property (ld_vec && ld_vec_idx[3] |-> m64_run)
    else $error("upper halves loaded outside wide mode");
  vec_gate_a: assert property ((os_save_enable && extended_feature_enable[2]) [*2] |-> vec_allowed)
    else $error("vector use not allowed");
  bnd_gate_a: assert property (!(os_save_enable && extended_feature_enable[4:3] == 2'b11) [*2]
    |-> !bounds_allowed)
    else $error("bounds allowed without enables");
  fmt_sel_a: assert property (done |-> fmt_compacted == cmp_run)
    else $error("format flag wrong");
  std_offs_a: assert property (done && !cmp_run |-> query_offset_vec == VEC_OFF
    && query_offset_breg == BREG_OFF && query_offset_bcfg == BCFG_OFF
    && query_size_vec == VEC_SIZE)
    else $error("standard offsets wrong");
endmodule // ssa_engine_props
bind ssa_engine ssa_engine_props #(.VEC_OFF(VEC_OFF), .VEC_SIZE(VEC_SIZE),
  .BREG_OFF(BREG_OFF), .BCFG_OFF(BCFG_OFF)) u_props (.*);
`default_nettype wire

// >>> tb/ssa_core_model.sv
// Core state model that tallies restore loads
`default_nettype none
module ssa_core_model (
  input  wire logic       clock,
  input  wire logic       clr,
  input  wire logic       ld_stack,
  input  wire logic       ld_simd,
  input  wire logic       ld_vec,
  input  wire logic       ld_breg,
  output var  logic [7:0] n_stack,
  output var  logic [7:0] n_simd,
  output var  logic [7:0] n_vec,
  output var  logic [7:0] n_breg
);
  always @(posedge clock) begin
    if (clr) begin
      n_stack <= 8'h00;
      n_simd <= 8'h00;
      n_vec <= 8'h00;
      n_breg <= 8'h00;
    end else begin
      n_stack <= n_stack + {7'h00, ld_stack === 1'b1};
      n_simd <= n_simd + {7'h00, ld_simd === 1'b1};
      n_vec <= n_vec + {7'h00, ld_vec === 1'b1};
      n_breg <= n_breg + {7'h00, ld_breg === 1'b1};
    end
  end
endmodule // ssa_core_model
`default_nettype wire

// >>> tb/ssa_engine_tb.sv
// Self-checking bench for the save area engine
`default_nettype none
module ssa_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clock, rst_n, save_req, restore_req, efe_wr, query_sel_dep, pm_clr;
  logic          wide_operand_prefix_bit, mode64, os_save_enable, busy, done, fault;
  logic          fmt_compacted, vec_allowed, bounds_allowed, ld_fp, ld_stack, ld_simd_csr;
  logic          ld_simd, ld_vec, ld_breg, ld_bcfg;
  logic [1:0]    ld_breg_idx;
  logic [2:0]    ld_stack_idx;
  logic [3:0]    ld_simd_idx, ld_vec_idx;
  logic [4:0]    req_mask, efe_wdata, extended_feature_enable;
  logic [7:0]    n_stack, n_simd, n_vec, n_breg;
  logic [9:0]    query_offset_vec, query_offset_breg, query_offset_bcfg, query_size_vec;
  logic [10:0]   fp_last_opcode, ld_fp_last_opcode;
  logic [15:0]   fp_control_word, fp_status_word, fp_tag_word, fp_code_selector;
  logic [15:0]   fp_data_selector, ld_fp_control_word, ld_fp_status_word, ld_fp_tag_word;
  logic [15:0]   ld_fp_code_selector, ld_fp_data_selector;
  logic [31:0]   simd_control_status, ld_simd_control_status, sel_e;
  logic [63:0]   compaction_bitmap, fp_instr_pointer, fp_data_pointer, bounds_user_config;
  logic [63:0]   bounds_status_reg, ld_fp_instr_pointer, ld_fp_data_pointer, m;
  logic [63:0]   ld_bounds_user_config, ld_bounds_status_reg;
  logic [79:0]   ld_stack_value;
  logic [127:0]  ld_simd_value, ld_vec_value, ld_breg_value;
  logic [511:0]  bounds_regs_component;
  logic [639:0]  fp_stack_regs;
  logic [2047:0] simd128_regs, vector256_upper_halves, rw, rv;
  integer        seed, num_errors, num_checks, cyc, it, k;
  ssa_engine DUT (.*);
  ssa_core_model PM (.clock(clock), .clr(pm_clr), .ld_stack(ld_stack), .ld_simd(ld_simd),
    .ld_vec(ld_vec), .ld_breg(ld_breg), .n_stack(n_stack), .n_simd(n_simd), .n_vec(n_vec),
    .n_breg(n_breg));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    begin
      num_checks++;
      if (g !== e) begin
        $display("ERROR %s expected %h seen %h", nm, e, g);
        num_errors++;
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("Checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task op(input logic s);
    integer n;
    begin
      n = 0;
      @(posedge clock);
      save_req <= s;
      restore_req <= !s;
      @(posedge clock);
      save_req <= 1'b0;
      restore_req <= 1'b0;
      do begin
        @(negedge clock);
        n++;
      end while (done !== 1'b1 && n < 200);
      chk("done", 1'b1, done);
    end
  endtask
  task wefe(input logic [4:0] v);
    begin
      @(posedge clock);
      efe_wr <= 1'b1;
      efe_wdata <= v;
      @(posedge clock);
      efe_wr <= 1'b0;
      repeat (3) @(negedge clock);
    end
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  // Each stack, SIMD, vector and bounds register load strobe carries the saved value back
  always @(negedge clock) begin
    if (ld_stack === 1'b1)
      chk("stack", fp_stack_regs[ld_stack_idx*80 +: 80], ld_stack_value);
    if (ld_simd === 1'b1)
      chk("simd", simd128_regs[ld_simd_idx*128 +: 128], ld_simd_value);
    if (ld_vec === 1'b1)
      chk("vec", vector256_upper_halves[ld_vec_idx*128 +: 128], ld_vec_value);
    if (ld_breg === 1'b1)
      chk("breg", bounds_regs_component[ld_breg_idx*128 +: 128], ld_breg_value);
  end
  initial begin
    seed = 32'he2d2;
    {num_errors, num_checks, cyc} = 0;
    {rst_n, save_req, restore_req, efe_wr, query_sel_dep, pm_clr} = 6'h01;
    {wide_operand_prefix_bit, mode64, os_save_enable, efe_wdata} = 8'h00;
    {req_mask, compaction_bitmap, simd_control_status} = {5'h1f, 96'h0};
    {fp_control_word, fp_status_word, fp_tag_word, fp_code_selector} = 64'h0;
    {fp_data_selector, fp_last_opcode, fp_instr_pointer, fp_data_pointer} = 155'h0;
    {fp_stack_regs, simd128_regs, vector256_upper_halves} = 4736'h0;
    {bounds_regs_component, bounds_user_config, bounds_status_reg} = 640'h0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk("efe_rst", 5'h01, extended_feature_enable);
    chk("tag_rst", 16'hffff, ld_fp_tag_word);
    @(posedge clock);
    save_req <= 1'b1;
    repeat (3) @(negedge clock);
    chk("busy_off", 1'b0, busy);
    @(posedge clock);
    save_req <= 1'b0;
    os_save_enable <= 1'b1;
    wefe(5'h00);
    chk("efe0", 5'h01, extended_feature_enable);
    wefe(5'h0f);
    chk("bnd_off", 1'b0, bounds_allowed);
    chk("vec_on", 1'b1, vec_allowed);
    wefe(5'h1b);
    chk("vec_off", 1'b0, vec_allowed);
    wefe(5'h1f);
    chk("bnd_on", 1'b1, bounds_allowed);
    for (it = 0; it < 10; it++) begin
      @(posedge clock);
      for (k = 0; k < 64; k++) begin
        rw[k*32 +: 32] = $random(seed);
        rv[k*32 +: 32] = $random(seed);
      end
      simd128_regs <= rw;
      vector256_upper_halves <= rv;
      fp_stack_regs <= rv[1023:384];
      bounds_regs_component <= rw[1023:512];
      {fp_instr_pointer, fp_data_pointer, bounds_user_config, bounds_status_reg} <= rw[1279:1024];
      {fp_control_word, fp_status_word, fp_code_selector, fp_data_selector} <= rv[1087:1024];
      fp_tag_word <= (it == 0) ? 16'hffff : (it == 1) ? 16'h0000 : rv[1103:1088];
      fp_last_opcode <= rv[1114:1104];
      simd_control_status <= (it == 9) ? 32'h00010000 : {16'h0000, rv[1135:1120]};
      {mode64, wide_operand_prefix_bit} <= it[1:0];
      query_sel_dep <= it[0] ^ it[2];
      compaction_bitmap <= {it[2], 58'h0, 5'h1f};
      pm_clr <= 1'b1;
      op(1'b1);
      pm_clr <= 1'b0;
      query_sel_dep <= 1'b0;
      op(1'b0);
      m = {{32{wide_operand_prefix_bit}}, 32'hffffffff};
      if (!it[0]) sel_e = it[2] ? 32'h0 : {fp_code_selector, fp_data_selector};
      if (it == 9) begin
        chk("fault", 1'b1, fault);
      end else begin
        chk("fault", 1'b0, fault);
        chk("csr", simd_control_status, ld_simd_control_status);
        chk("cw", fp_control_word, ld_fp_control_word);
        chk("sw", fp_status_word, ld_fp_status_word);
        chk("opc", fp_last_opcode, ld_fp_last_opcode);
        chk("ip", fp_instr_pointer & m, ld_fp_instr_pointer & m);
        chk("dp", fp_data_pointer & m, ld_fp_data_pointer & m);
        chk("cs", sel_e[31:16], ld_fp_code_selector);
        chk("ds", sel_e[15:0], ld_fp_data_selector);
        chk("bcfg", {bounds_user_config, bounds_status_reg},
          {ld_bounds_user_config, ld_bounds_status_reg});
        for (k = 0; k < 8; k++)
          chk("tag", fp_tag_word[2*k +: 2] == 2'h3, ld_fp_tag_word[2*k +: 2] == 2'h3);
        chk("n_stack", 8'd8, n_stack);
        chk("n_simd", mode64 ? 8'd16 : 8'd8, n_simd);
        chk("n_vec", mode64 ? 8'd16 : 8'd8, n_vec);
        chk("n_breg", 8'd4, n_breg);
      end
      chk("fmt", it[2], fmt_compacted);
      if (!it[2])
        chk("offs", {10'd576, 10'd832, 10'd896},
          {query_offset_vec, query_offset_breg, query_offset_bcfg});
    end
    tally_and_finish;
  end
endmodule // ssa_engine_tb
`default_nettype wire
